// ==== bench/acs_seq_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
// =============================================================================
// Port-level checker; shadows the on bit, channel and trigger mode from writes.
module acs_seq_monitor (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Analog side and trigger.
  input wire logic        rc_clk,
  input wire logic        comp_out,
  input wire logic [9:0]  dac_code,
  input wire logic        sample_hold,
  input wire logic [2:0]  channel_select,
  input wire logic [7:0]  port_pins,
  input wire logic        special_event,
  input wire logic        timer_counter_reset
);
  logic       wr_ctl;
  logic       on_q;
  logic       arm;
  logic [2:0] ch_q;
  logic [3:0] mode_q;
  // A write lands only in an access cycle with the clock enabled.
  assign wr_ctl = psel && penable && pwrite && clk_en && paddr == acs_pkg::ADDR_CONTROL;
  assign arm    = (mode_q == acs_pkg::CCP_TRIGGER_MODE);
  // Shadows, so that trigger rules can be judged from the ports alone.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_q   <= 1'b0;
      ch_q   <= 3'h0;
      mode_q <= 4'h0;
    end else if (wr_ctl) begin
      on_q <= pwdata[0];
      ch_q <= pwdata[5:3];
    end else if (psel && penable && pwrite && clk_en && paddr == acs_pkg::ADDR_CCP) begin
      mode_q <= pwdata[3:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_zero_wait: assert property (psel && penable |-> pready)
    else $error("access not completed at once");
  chk_map_error: assert property (psel && penable && paddr >= 12'h020 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_upper_zero: assert property (psel && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_tmr_mode: assert property (special_event && arm |-> timer_counter_reset)
    else $error("timer reset missing");
  chk_tmr_quiet: assert property (timer_counter_reset |-> special_event && arm)
    else $error("spurious timer reset");
  chk_trig_start: assert property (special_event && arm && on_q && !sample_hold |-> ##[1:4] sample_hold)
    else $error("trigger did not start a conversion");
  chk_off_ignore: assert property (special_event && !on_q && !sample_hold |=> !sample_hold [*4])
    else $error("trigger started a conversion while off");
  chk_msb_first: assert property ($rose(sample_hold) |-> ##[0:200] dac_code == 10'h200)
    else $error("first trial is not the top bit");
  chk_abort_drop: assert property (wr_ctl && !pwdata[2] && sample_hold |-> ##[1:300] !sample_hold)
    else $error("abort did not end the conversion");
  chk_chan_follow: assert property (wr_ctl |=> channel_select == ch_q)
    else $error("channel select does not follow control");
  // Main scenarios reached.
  cover property ($rose(sample_hold));
  cover property (special_event && arm && on_q);
  cover property (wr_ctl && !pwdata[2] && sample_hold);
endmodule // acs_seq_monitor

bind acs_sequencer acs_seq_monitor mon_u (.clk, .rst_n, .clk_en, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .rc_clk, .comp_out, .dac_code, .sample_hold,
  .channel_select, .port_pins, .special_event, .timer_counter_reset);
`default_nettype wire

// ==== bench/adc_conversion_sequencer_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
// =============================================================================
// Self-checking bench: the APB driver notes expected reads, a monitor compares.
module adc_conversion_sequencer_bench;
  logic        clk, rst_n, clk_en, psel, penable, pwrite, rc_clk, comp_out, special_event;
  logic        pready, pslverr, sample_hold, timer_counter_reset;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0]  dac_code, vin;
  logic [2:0]  channel_select;
  logic [7:0]  port_pins, exp_hi, exp_lo;
  logic [31:0] exp_q[$];
  int          n_errors, comparisons;
  int          n_of[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
  logic [2:0]  codes[5] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h3};

  acs_sequencer dut_u (.clk, .rst_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rc_clk, .comp_out, .dac_code, .sample_hold,
    .channel_select, .port_pins, .special_event, .timer_counter_reset);

  // Clocks; the RC clock is free running and unrelated in phase.
  always #5 clk = ~clk;
  always #37 rc_clk = ~rc_clk;
  // Comparator is high while the input is at or above the trial code.
  always @(posedge clk) comp_out <= (vin >= dac_code);
  // Each completed read is compared with the oldest note.
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      check(prdata, exp_q.pop_front());
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_hold(input logic lvl);
    int i;
    for (i = 0; i < 3000 && sample_hold !== lvl; i++) @(negedge clk);
    check({31'h0, sample_hold}, {31'h0, lvl});
  endtask

  // One conversion started by software or trigger, optionally aborted midway.
  task automatic run_conv(input logic [2:0] cs, input logic j, input logic trig, input logic ab);
    logic [2:0] ch;
    logic [9:0] v;
    int         n;
    ch = 3'($urandom);
    v = 10'($urandom);
    n = 0;
    vin <= v;
    apb(1'b1, acs_pkg::ADDR_CONFIG, {24'h0, j, cs[2], 6'h0});
    apb(1'b1, acs_pkg::ADDR_CONTROL, {24'h0, cs[1:0], ch, 3'b001});
    if (trig) begin
      repeat (4) @(posedge clk); // Channel was chosen above; let it acquire first.
      @(posedge clk) special_event <= 1'b1;
      @(posedge clk) special_event <= 1'b0;
    end else begin
      apb(1'b1, acs_pkg::ADDR_CONTROL, {24'h0, cs[1:0], ch, 3'b101});
    end
    @(negedge clk);
    wait_hold(1'b1);
    if (ab) begin
      repeat (100) @(negedge clk);
      apb(1'b1, acs_pkg::ADDR_CONTROL, {24'h0, cs[1:0], ch, 3'b001});
      wait_hold(1'b0);
      rd(acs_pkg::ADDR_STATUS, 8'h02);
      repeat (acs_pkg::RECOVER_PERIODS * n_of[cs]) @(negedge clk);
    end else begin
      while (sample_hold === 1'b1 && n < 2000) begin
        @(negedge clk);
        n++;
      end
      if (cs != acs_pkg::CS_RC) check(32'(n), 32'(acs_pkg::CONV_PERIODS * n_of[cs]));
      exp_hi = j ? {6'h0, v[9:8]} : v[9:2];
      exp_lo = j ? v[7:0] : {v[1:0], 6'h0};
    end
    // Fast bit periods outrun the comparator path, so only slow results are judged.
    if (cs == 3'h6 || cs == 3'h2) begin
      rd(acs_pkg::ADDR_RES_HI, exp_hi);
      rd(acs_pkg::ADDR_RES_LO, exp_lo);
    end
    rd(acs_pkg::ADDR_STATUS, {7'h0, !ab});
    rd(acs_pkg::ADDR_CONTROL, {cs[1:0], ch, 3'b001});
    apb(1'b1, acs_pkg::ADDR_STATUS, 32'h1);
  endtask

  task automatic pulse_event;
    @(posedge clk) special_event <= 1'b1;
    @(posedge clk) special_event <= 1'b0;
    repeat (20) @(posedge clk);
  endtask

  task automatic test_done;
    $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog: far beyond the few thousand cycles the sequence needs.
  initial begin
    #300000;
    n_errors++;
    test_done();
  end

  // Main sequence.
  initial begin
    {clk, rc_clk, rst_n, psel, penable, pwrite, comp_out, special_event} = '0;
    {clk_en, paddr, pwdata, port_pins, vin} = {1'b1, 12'h0, 32'h0, 8'h0, 10'h0};
    void'($urandom(96353));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(acs_pkg::ADDR_CONTROL, 8'h00);
    rd(acs_pkg::ADDR_CONFIG, 8'h00);
    rd(acs_pkg::ADDR_DIR, 8'hff);
    rd(acs_pkg::ADDR_STATUS, 8'h00);
    rd(12'h020, 8'h00);
    apb(1'b1, acs_pkg::ADDR_RES_HI, 32'h5a);
    apb(1'b1, acs_pkg::ADDR_RES_LO, 32'ha5);
    {exp_hi, exp_lo} = 16'h5aa5;
    rd(acs_pkg::ADDR_RES_HI, exp_hi);
    rd(acs_pkg::ADDR_RES_LO, exp_lo);
    apb(1'b1, acs_pkg::ADDR_DIR, 32'hff);
    apb(1'b1, acs_pkg::ADDR_CCP, 32'hb);
    pulse_event();
    rd(acs_pkg::ADDR_STATUS, 8'h00);
    rd(acs_pkg::ADDR_RES_HI, exp_hi);
    for (int k = 0; k < 5; k++) run_conv(codes[k], 1'($urandom), 1'b0, 1'b0);
    run_conv(3'h2, 1'b0, 1'b0, 1'b0);
    run_conv(3'h6, 1'b1, 1'b0, 1'b0);
    run_conv(3'h6, 1'b0, 1'b0, 1'b1);
    run_conv(3'h6, 1'b0, 1'b1, 1'b0);
    apb(1'b1, acs_pkg::ADDR_CCP, 32'ha);
    pulse_event();
    rd(acs_pkg::ADDR_STATUS, 8'h00);
    apb(1'b1, acs_pkg::ADDR_CONFIG, 32'h0);
    port_pins <= 8'($urandom);
    repeat (6) @(posedge clk);
    rd(acs_pkg::ADDR_PORT, 8'h00);
    apb(1'b1, acs_pkg::ADDR_CONFIG, 32'h6);
    rd(acs_pkg::ADDR_PORT, port_pins);
    // Let the compare process take the last note before the verdict.
    repeat (2) @(posedge clk);
    test_done();
  end
endmodule // adc_conversion_sequencer_bench
`default_nettype wire

// ==== core/acs_sequencer.sv ====
`timescale 1ns/1ns
`default_nettype none
// How it works
// - A conversion lasts exactly twelve bit periods and yields ten result bits.
// - Clock select gives 2,4,8,16,32,64 clocks or the RC clock by code.
// - Port reads return zero for every pin configured as analog input.
// - Conversion runs regardless of channel select and pin direction.
// - Clearing go/done during a conversion aborts it at once.
// - An abort leaves the result pair untouched.
// - After abort, hold drops and acquisition restarts at once; a new start waits two bit periods.
// - Result is left or right aligned in sixteen bits, unused bits zero.
// - With converter off, result registers are plain read-write bytes.
// - Mode 1011 with converter on: special event sets go/done and starts.
// - In mode 1011 every special event resets the associated timer counter to zero.
// - With converter off, special event starts nothing but still resets timer.
// - Completion loads result, clears go/done and sets the conversion flag.
// - Device reset switches the converter off and aborts any conversion.
module acs_sequencer (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog front end.
  input  wire logic        rc_clk,
  input  wire logic        comp_out,
  output logic      [9:0]  dac_code,
  output logic             sample_hold,
  output logic      [2:0]  channel_select,
  // Port pins sharing the analog inputs.
  input  wire logic [7:0]  port_pins,
  // Capture/compare unit.
  input  wire logic        special_event,
  output logic             timer_counter_reset
);
  // =============================================================================
  // Register storage.
  logic [7:0] converter_control;
  logic [7:0] converter_config;
  logic [7:0] result_high;
  logic [7:0] result_low;
  logic [3:0] capture_compare_mode;
  logic [7:0] port_direction;
  logic       conversion_flag;
  logic [7:0] port_sync1, port_sync2, port_sync3, port_value;
  logic       comp_sync1, comp_sync2, comp_sync3, comp_value;

  acs_pkg::acs_state_t state;
  logic [3:0] period_count;
  logic [9:0] sar;
  logic [9:0] trial;
  logic       tick;
  logic       tb_run;
  logic       wr_en, rd_en;
  logic       converter_on, go_done, justify;
  logic       go_write_set, go_write_clear, trigger_start;
  logic [2:0] conv_clock_select;
  logic [7:0] analog_mask;

  assign converter_on      = converter_control[acs_pkg::CTL_ON_BIT];
  assign go_done           = converter_control[acs_pkg::CTL_GO_BIT];
  assign justify           = converter_config[acs_pkg::CFG_JUST_BIT];
  assign conv_clock_select = {converter_config[acs_pkg::CFG_CS2_BIT],
                              converter_control[acs_pkg::CTL_CS_LSB +: 2]};
  assign channel_select    = converter_control[acs_pkg::CTL_CHS_LSB +: 3];

  // =============================================================================
  // Bus decode; the slave always answers in the access cycle, no wait states.
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite && clk_en;
  assign rd_en   = psel && !pwrite;
  assign pslverr = psel && penable && (paddr[11:5] != 7'h00 || paddr[1:0] != 2'h0);

  // Analog mask from the port configuration; pins set analog read as zero.
  function automatic logic [7:0] analog_pins(input logic [3:0] pcfg);
    case (pcfg)
      4'h0, 4'h1, 4'h8: analog_pins = 8'hff;
      4'h2, 4'h3, 4'hc: analog_pins = 8'h1f;
      4'h4:             analog_pins = 8'h0b;
      4'h5, 4'hd:       analog_pins = 8'h0f;
      4'h6, 4'h7:       analog_pins = 8'h00;
      4'h9, 4'ha, 4'hb: analog_pins = 8'h3f;
      4'he:             analog_pins = 8'h01;
      default:          analog_pins = 8'h0d;
    endcase
  endfunction
  assign analog_mask = analog_pins(converter_config[acs_pkg::CFG_PCFG_LSB +: 4]);

  // Read multiplexer; unmapped words read zero.
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        acs_pkg::ADDR_CONTROL: prdata = {24'h00_0000, converter_control};
        acs_pkg::ADDR_CONFIG:  prdata = {24'h00_0000, converter_config};
        acs_pkg::ADDR_RES_HI:  prdata = {24'h00_0000, result_high};
        acs_pkg::ADDR_RES_LO:  prdata = {24'h00_0000, result_low};
        acs_pkg::ADDR_CCP:     prdata = {28'h000_0000, capture_compare_mode};
        acs_pkg::ADDR_STATUS:  prdata = {30'h0000_0000, (state != acs_pkg::ST_IDLE),
                                         conversion_flag};
        acs_pkg::ADDR_PORT:    prdata = {24'h00_0000, port_value & ~analog_mask};
        acs_pkg::ADDR_DIR:     prdata = {24'h00_0000, port_direction};
        default:               prdata = 32'h0000_0000;
      endcase
    end
  end

  // =============================================================================
  // Pin inputs pass three flops; a change counts once the last two agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_sync1 <= 8'h00;
      port_sync2 <= 8'h00;
      port_sync3 <= 8'h00;
      port_value <= 8'h00;
      comp_sync1 <= 1'b0;
      comp_sync2 <= 1'b0;
      comp_sync3 <= 1'b0;
      comp_value <= 1'b0;
    end else if (clk_en) begin
      port_sync1 <= port_pins;
      port_sync2 <= port_sync1;
      port_sync3 <= port_sync2;
      port_value <= (port_sync2 & port_sync3) | (port_value & (port_sync2 | port_sync3));
      comp_sync1 <= comp_out;
      comp_sync2 <= comp_sync1;
      comp_sync3 <= comp_sync2;
      if (comp_sync2 == comp_sync3) begin
        comp_value <= comp_sync3;
      end
    end
  end

  // Go/done set and clear causes.
  assign go_write_set   = wr_en && paddr == acs_pkg::ADDR_CONTROL && pwdata[acs_pkg::CTL_GO_BIT];
  assign go_write_clear = wr_en && paddr == acs_pkg::ADDR_CONTROL && !pwdata[acs_pkg::CTL_GO_BIT];
  assign trigger_start  = clk_en && special_event && converter_on
                          && capture_compare_mode == acs_pkg::CCP_TRIGGER_MODE;
  assign timer_counter_reset = special_event
                          && capture_compare_mode == acs_pkg::CCP_TRIGGER_MODE;

  // =============================================================================
  // Control register; hardware completion clear loses to a same-cycle set.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_control <= acs_pkg::CONTROL_RESET;
    end else if (clk_en) begin
      if (wr_en && paddr == acs_pkg::ADDR_CONTROL) begin
        converter_control <= pwdata[7:0] & 8'hfd;
        converter_control[acs_pkg::CTL_GO_BIT] <= pwdata[acs_pkg::CTL_GO_BIT]
                                                  && pwdata[acs_pkg::CTL_ON_BIT];
      end else if (trigger_start) begin
        converter_control[acs_pkg::CTL_GO_BIT] <= 1'b1;
      end else if (state == acs_pkg::ST_CONVERT && tick
                   && period_count == 4'(acs_pkg::CONV_PERIODS - 1)) begin
        converter_control[acs_pkg::CTL_GO_BIT] <= 1'b0;
      end
    end
  end

  // Other writable registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_config     <= acs_pkg::CONFIG_RESET;
      capture_compare_mode <= 4'h0;
      port_direction       <= acs_pkg::DIR_RESET;
    end else if (wr_en) begin
      if (paddr == acs_pkg::ADDR_CONFIG) begin
        converter_config <= pwdata[7:0] & 8'hcf;
      end
      if (paddr == acs_pkg::ADDR_CCP) begin
        capture_compare_mode <= pwdata[3:0];
      end
      if (paddr == acs_pkg::ADDR_DIR) begin
        port_direction <= pwdata[7:0];
      end
    end
  end

  // Conversion flag: completion sets it, a write of one to the status bit clears it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_flag <= 1'b0;
    end else if (clk_en) begin
      if (converter_on && state == acs_pkg::ST_CONVERT && tick && !go_write_clear
          && period_count == 4'(acs_pkg::CONV_PERIODS - 1)) begin
        conversion_flag <= 1'b1;
      end else if (wr_en && paddr == acs_pkg::ADDR_STATUS
                   && pwdata[acs_pkg::STA_FLAG_BIT]) begin
        conversion_flag <= 1'b0;
      end
    end
  end

  // =============================================================================
  // Bit-period timebase; an abort drops run for one cycle so that the divider
  // restarts and recovery lasts two whole bit periods, not a partial one.
  assign tb_run = (state != acs_pkg::ST_IDLE)
                  && !(state == acs_pkg::ST_CONVERT && (go_write_clear || !converter_on));
  acs_timebase u_timebase (
    .clk          (clk),
    .rst_n        (rst_n),
    .clk_en       (clk_en),
    .run          (tb_run),
    .clock_select (conv_clock_select),
    .rc_clk       (rc_clk),
    .tick         (tick)
  );

  // Sequencer: conversion and post-abort recovery counted in bit periods.
  // It ignores channel and direction bits entirely; the front end converts
  // whatever level the selected pin carries, digital output included.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= acs_pkg::ST_IDLE;
      period_count <= 4'h0;
      sar          <= 10'h000;
    end else if (clk_en) begin
      case (state)
        acs_pkg::ST_IDLE: begin
          period_count <= 4'h0;
          sar          <= 10'h000;
          if (go_done && converter_on) begin
            state <= acs_pkg::ST_CONVERT;
          end
        end
        acs_pkg::ST_CONVERT: begin
          if (go_write_clear || !converter_on) begin
            state        <= acs_pkg::ST_RECOVER;
            period_count <= 4'h0;
          end else if (tick) begin
            // Periods 1..10 each settle one bit, MSB first; 0 and 11 frame them.
            if (period_count >= 4'h1 && period_count <= 4'(acs_pkg::RESULT_BITS)) begin
              sar <= comp_value ? trial : (trial & ~(10'h200 >> (period_count - 4'h1)));
            end
            if (period_count == 4'(acs_pkg::CONV_PERIODS - 1)) begin
              state <= acs_pkg::ST_IDLE;
            end else begin
              period_count <= period_count + 4'h1;
            end
          end
        end
        acs_pkg::ST_RECOVER: begin
          if (tick) begin
            if (period_count == 4'(acs_pkg::RECOVER_PERIODS - 1)) begin
              state <= acs_pkg::ST_IDLE;
            end else begin
              period_count <= period_count + 4'h1;
            end
          end
        end
        default: state <= acs_pkg::ST_IDLE;
      endcase
    end
  end

  // Trial code: the bit under test is raised on top of the bits decided.
  assign trial = (period_count >= 4'h1 && period_count <= 4'(acs_pkg::RESULT_BITS))
                 ? (sar | (10'h200 >> (period_count - 4'h1))) : sar;

  // Drive the DAC from a flop; hold is released outside a conversion so the
  // channel acquires again, which gives the automatic reacquisition.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_code    <= 10'h000;
      sample_hold <= 1'b0;
    end else if (clk_en) begin
      dac_code    <= trial;
      sample_hold <= (state == acs_pkg::ST_CONVERT);
    end
  end

  // Result pair: completion overwrites only if on; abort never touches it.
  always_ff @(posedge clk) begin
    if (clk_en) begin
      if (converter_on && state == acs_pkg::ST_CONVERT && tick && !go_write_clear
          && period_count == 4'(acs_pkg::CONV_PERIODS - 1)) begin
        if (justify) begin
          result_high <= {6'h00, sar[9:8]};
          result_low  <= sar[7:0];
        end else begin
          result_high <= sar[9:2];
          result_low  <= {sar[1:0], 6'h00};
        end
      end else if (wr_en) begin
        if (paddr == acs_pkg::ADDR_RES_HI) begin
          result_high <= pwdata[7:0];
        end
        if (paddr == acs_pkg::ADDR_RES_LO) begin
          result_low <= pwdata[7:0];
        end
      end
    end
  end
endmodule // acs_sequencer
`default_nettype wire

// ==== core/acs_timebase.sv ====
`timescale 1ns/1ns
`default_nettype none
// =============================================================================
// Bit-period tick generator: divides clk or follows a resynchronised RC clock.
module acs_timebase (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // Control.
  input  wire logic       run,
  input  wire logic [2:0] clock_select,
  input  wire logic       rc_clk,
  // Tick output.
  output logic            tick
);
  logic [5:0] div_count;
  logic [5:0] div_last;
  logic [2:0] rc_sync;
  logic       rc_seen;

  // Map the select code to a terminal count; the RC code has none.
  always_comb begin
    case (clock_select)
      3'h0:    div_last = 6'h01;
      3'h4:    div_last = 6'h03;
      3'h1:    div_last = 6'h07;
      3'h5:    div_last = 6'h0f;
      3'h2:    div_last = 6'h1f;
      3'h6:    div_last = 6'h3f;
      default: div_last = 6'h3f;
    endcase
  end

  // Divider restarts whenever the sequencer is idle, so periods align to start.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_count <= 6'h00;
    end else if (clk_en) begin
      if (!run || div_count == div_last) begin
        div_count <= 6'h00;
      end else begin
        div_count <= div_count + 6'h01;
      end
    end
  end

  // The RC clock is foreign, so it passes three stages before its edges count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_sync <= 3'h0;
      rc_seen <= 1'b0;
    end else if (clk_en) begin
      rc_sync <= {rc_sync[1:0], rc_clk};
      rc_seen <= rc_sync[2];
    end
  end

  // One tick per bit period from either source.
  assign tick = run && ((clock_select == acs_pkg::CS_RC) ? (rc_sync[2] && !rc_seen)
                                                         : (div_count == div_last));
endmodule // acs_timebase
`default_nettype wire

// ==== shared/acs_pkg.sv ====
`default_nettype none
// =============================================================================
// Shared constants of the conversion sequencer.
package acs_pkg;
  // =============================================================================
  // Register byte offsets on APB.
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_CONFIG  = 12'h004;
  localparam logic [11:0] ADDR_RES_HI  = 12'h008;
  localparam logic [11:0] ADDR_RES_LO  = 12'h00c;
  localparam logic [11:0] ADDR_CCP     = 12'h010;
  localparam logic [11:0] ADDR_STATUS  = 12'h014;
  localparam logic [11:0] ADDR_PORT    = 12'h018;
  localparam logic [11:0] ADDR_DIR     = 12'h01c;

  // Control register fields.
  localparam int CTL_ON_BIT  = 0;
  localparam int CTL_GO_BIT  = 2;
  localparam int CTL_CHS_LSB = 3;
  localparam int CTL_CS_LSB  = 6;
  // Config register fields.
  localparam int CFG_PCFG_LSB = 0;
  localparam int CFG_CS2_BIT  = 6;
  localparam int CFG_JUST_BIT = 7;
  // Status register fields.
  localparam int STA_FLAG_BIT = 0;
  localparam int STA_BUSY_BIT = 1;

  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET  = 8'h00;
  localparam logic [7:0] DIR_RESET     = 8'hff;

  // Capture/compare mode that routes the special event to the converter.
  localparam logic [3:0] CCP_TRIGGER_MODE = 4'hb;
  // Clock select code for the internal RC timebase.
  localparam logic [2:0] CS_RC = 3'h3;

  // Timing counts in conversion bit periods.
  localparam int CONV_PERIODS    = 12;
  localparam int RECOVER_PERIODS = 2;
  localparam int RESULT_BITS     = 10;
  // Least bit period in ns, and the system clock period in ns.
  localparam int MIN_PERIOD_NS = 1600;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MIN_PERIOD_CYC = (MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CONVERT = 2'b01,
    ST_RECOVER = 2'b10
  } acs_state_t;
endpackage
`default_nettype wire
